// ==== src/rail_regs_pkg.sv ====
package rail_regs_pkg;

    // Register offsets on the internal register port
    localparam logic [7:0] TERM_DISCHARGE_CTRL_ADDR = 8'h00_AD;
    localparam logic [7:0] AUX_RAIL_CTRL_ADDR       = 8'h00_AE;
    localparam logic [7:0] RAIL_GOOD_STATUS_A_ADDR  = 8'h00_B0;

    // Field positions
    localparam int TERM_DISCHARGE_BIT   = 4;
    localparam int AUX_DISCHARGE_MSB    = 7;
    localparam int AUX_DISCHARGE_LSB    = 6;
    localparam int AUX_SHUTDOWN_BIT     = 5;
    localparam int AUX_VOLTAGE_MSB      = 4;
    localparam int AUX_VOLTAGE_LSB      = 1;
    localparam int AUX_ENABLE_BIT       = 0;

    // Reset values
    localparam logic [7:0] RAIL_GOOD_STATUS_A_RESET = 8'h00_00;
    localparam logic [7:0] CTRL_PRELOAD_RESET       = 8'h00_00;

    // Discharge resistor selections
    typedef enum logic [1:0] {
        DISCH_NONE,
        DISCH_100_OHM,
        DISCH_200_OHM,
        DISCH_500_OHM
    } discharge_e;

    // Emergency shutdown off times in ms, by OTP code
    localparam int SHUTDOWN_MS_0 = 1;
    localparam int SHUTDOWN_MS_1 = 5;
    localparam int SHUTDOWN_MS_2 = 10;
    localparam int SHUTDOWN_MS_3 = 100;
    localparam int CLK_HZ        = 25_000_000;
    localparam int CYCLES_PER_MS = CLK_HZ / 1000;

    // Factory option: which rail the auxiliary fields steer
    typedef enum logic [1:0] {
        TARGET_AUX_LDO,
        TARGET_SWITCH_B2,
        TARGET_UNUSED
    } aux_target_e;

    // Factory OTP image for the two control registers
    typedef struct packed {
        logic [7:0] term_ctrl;
        logic [7:0] aux_ctrl;
        logic [1:0] shutdown_time;
        logic       aux_in_sequence;
        logic       switches_b_merged;
        logic       aux_bit_unused;
    } otp_cfg_s;

    // Rail controls driven to the analog side
    typedef struct packed {
        logic       term_discharge_sel;
        discharge_e aux_discharge_sel;
        logic [3:0] aux_voltage_code;
        logic       aux_ldo_one_on;
        logic       load_switch_b2_on;
    } rail_ctrl_s;

endpackage : rail_regs_pkg

// ==== src/shutdown_timer.sv ====
`timescale 1ns/10ps
module shutdown_timer
    import rail_regs_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_MS
) (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       start_in,
    input  wire logic [1:0] time_sel_in,
    output logic            off_out
);

    // Zero cycles per ms would make every off time vanish
    if (MS_CYCLES < 1) begin : g_ms_check
        $error("MS_CYCLES must be at least one");
    end

    localparam int CNT_W = $clog2(SHUTDOWN_MS_3 * MS_CYCLES + 1);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;

    function automatic logic [CNT_W-1:0] span(input logic [1:0] sel);
        case (sel)
            2'h0: span = CNT_W'(SHUTDOWN_MS_0 * MS_CYCLES);
            2'h1: span = CNT_W'(SHUTDOWN_MS_1 * MS_CYCLES);
            2'h2: span = CNT_W'(SHUTDOWN_MS_2 * MS_CYCLES);
            default: span = CNT_W'(SHUTDOWN_MS_3 * MS_CYCLES);
        endcase
    endfunction : span

    // Reload on each start so a repeated shutdown restarts the off time
    always_comb begin
        count_d = count_q;
        if (start_in) begin
            count_d = span(time_sel_in);
        end else if (count_q != '0) begin
            count_d = count_q - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign off_out = (count_q != '0);

endmodule : shutdown_timer

// ==== src/rail_control_status_regs.sv ====
`timescale 1ns/10ps
// Behaviour
// - Termination discharge bit 4: clear gives none, set gives 100 ohm.
// - Aux discharge bits 7:6: none, 100, 200, 500 ohm.
// - Shutdown cfg 0: aux rail off for OTP time 1/5/10/100 ms on shutdown.
// - Shutdown cfg 1: aux rail ignores shutdown, follows enable bit only.
// - Aux in sequence, B switches unmerged, aux bit in use: fields steer load switch B2.
// - Voltage code bits 4:1 sets aux LDO output voltage.
// - Bit 0 disables or enables the selected rail; unused on some options.
// - Each power-good bit reads 1 while its rail is in regulation.
// - Good bits: 7 aux LDO two, 6 switch A1, 5..0 converters six..one.
// - Power-good status is read-only at B0h, reset zero.
module rail_control_status_regs
    import rail_regs_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_MS
) (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire otp_cfg_s   otp_cfg_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic [7:0]      reg_rdata_out,
    output logic            reg_ready_out,
    output logic            reg_hit_out,
    input  wire logic       emergency_shutdown_in,
    input  wire logic       aux_two_good_in,
    input  wire logic       switch_a1_good_in,
    input  wire logic       converter6_good_in,
    input  wire logic       converter5_good_in,
    input  wire logic       converter4_good_in,
    input  wire logic       converter3_good_in,
    input  wire logic       converter2_good_in,
    input  wire logic       converter1_good_in,
    output rail_ctrl_s      rail_ctrl_out
);

    // Refuse a tick rate the off-time counter cannot serve
    if (MS_CYCLES < 1) begin : g_ms_check
        $error("MS_CYCLES must be at least one");
    end

    typedef enum logic {
        ST_LOAD,
        ST_RUN
    } load_state_e;

    load_state_e state_q;
    load_state_e state_d;
    logic [7:0]  term_ctrl_q;
    logic [7:0]  term_ctrl_d;
    logic [7:0]  aux_ctrl_q;
    logic [7:0]  aux_ctrl_d;
    logic [1:0]  shut_time_q;
    logic [1:0]  shut_time_d;
    aux_target_e target_q;
    aux_target_e target_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic [7:0]  good_meta_q;
    logic [7:0]  good_sync_q;
    logic [7:0]  status_q;
    logic [7:0]  status_d;
    logic [1:0]  esd_sync_q;
    logic        esd_prev_q;
    logic        esd_start;
    logic        esd_off;
    logic        rail_on;
    logic [7:0]  good_raw;

    // Rail good pins come from analog comparators
    assign good_raw = {aux_two_good_in, switch_a1_good_in,
                       converter6_good_in, converter5_good_in,
                       converter4_good_in, converter3_good_in,
                       converter2_good_in, converter1_good_in};

    // Synchronisers for asynchronous analog levels
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            good_meta_q <= 8'h00_00;
            good_sync_q <= 8'h00_00;
            esd_sync_q  <= 2'h0;
            esd_prev_q  <= 1'b0;
        end else begin
            good_meta_q <= good_raw;
            good_sync_q <= good_meta_q;
            esd_sync_q  <= {esd_sync_q[0], emergency_shutdown_in};
            esd_prev_q  <= esd_sync_q[1];
        end
    end

    assign esd_start = esd_sync_q[1] && !esd_prev_q;

    // Status mirrors the synchronised rail good levels
    always_comb begin
        status_d = good_sync_q;
    end

    // Control register load, host writes and read mux
    always_comb begin
        state_d     = ST_RUN;
        term_ctrl_d = term_ctrl_q;
        aux_ctrl_d  = aux_ctrl_q;
        shut_time_d = shut_time_q;
        target_d    = target_q;
        rdata_d     = rdata_q;
        if (state_q == ST_LOAD) begin
            term_ctrl_d = otp_cfg_in.term_ctrl;
            aux_ctrl_d  = otp_cfg_in.aux_ctrl;
            shut_time_d = otp_cfg_in.shutdown_time;
            if (otp_cfg_in.aux_bit_unused) begin
                target_d = TARGET_UNUSED;
            end else if (otp_cfg_in.aux_in_sequence && !otp_cfg_in.switches_b_merged) begin
                target_d = TARGET_SWITCH_B2;
            end else begin
                target_d = TARGET_AUX_LDO;
            end
        end else begin
            if (reg_wr_in) begin
                case (reg_addr_in)
                    // Reserved bits stored as written; host must copy OTP there
                    TERM_DISCHARGE_CTRL_ADDR: term_ctrl_d = reg_wdata_in;
                    AUX_RAIL_CTRL_ADDR:       aux_ctrl_d  = reg_wdata_in;
                    default:                  ;
                endcase
            end
            if (reg_rd_in) begin
                case (reg_addr_in)
                    TERM_DISCHARGE_CTRL_ADDR: rdata_d = term_ctrl_q;
                    AUX_RAIL_CTRL_ADDR:       rdata_d = aux_ctrl_q;
                    RAIL_GOOD_STATUS_A_ADDR:  rdata_d = status_q;
                    default:                  rdata_d = 8'h00_00;
                endcase
            end
        end
    end

    // Registers hold the reset preload until the load state ends, then take OTP
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_q     <= ST_LOAD;
            term_ctrl_q <= CTRL_PRELOAD_RESET;
            aux_ctrl_q  <= CTRL_PRELOAD_RESET;
            shut_time_q <= 2'h0;
            target_q    <= TARGET_AUX_LDO;
            rdata_q     <= 8'h00_00;
            status_q    <= RAIL_GOOD_STATUS_A_RESET;
        end else begin
            state_q     <= state_d;
            term_ctrl_q <= term_ctrl_d;
            aux_ctrl_q  <= aux_ctrl_d;
            shut_time_q <= shut_time_d;
            target_q    <= target_d;
            rdata_q     <= rdata_d;
            status_q    <= status_d;
        end
    end

    // Host may only access once OTP is loaded
    assign reg_ready_out = (state_q == ST_RUN);
    assign reg_hit_out   = (reg_addr_in == TERM_DISCHARGE_CTRL_ADDR)
                        || (reg_addr_in == AUX_RAIL_CTRL_ADDR)
                        || (reg_addr_in == RAIL_GOOD_STATUS_A_ADDR);
    assign reg_rdata_out = rdata_q;

    // Off-time counter only armed when shutdown cfg is zero
    shutdown_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_shutdown_timer (
        .clk_in      (clk_in),
        .rst_b_in    (rst_b_in),
        .start_in    (esd_start && !aux_ctrl_q[AUX_SHUTDOWN_BIT]),
        .time_sel_in (shut_time_q),
        .off_out     (esd_off)
    );

    // Shutdown cfg set means the enable bit alone decides
    always_comb begin
        rail_on = aux_ctrl_q[AUX_ENABLE_BIT];
        if (!aux_ctrl_q[AUX_SHUTDOWN_BIT] && esd_off) begin
            rail_on = 1'b0;
        end else if (aux_ctrl_q[AUX_SHUTDOWN_BIT]) begin
            rail_on = aux_ctrl_q[AUX_ENABLE_BIT];
        end
    end

    // Analog controls are driven from flops
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rail_ctrl_out <= '0;
        end else begin
            rail_ctrl_out.term_discharge_sel <= term_ctrl_q[TERM_DISCHARGE_BIT];
            rail_ctrl_out.aux_discharge_sel  <=
                discharge_e'(aux_ctrl_q[AUX_DISCHARGE_MSB:AUX_DISCHARGE_LSB]);
            rail_ctrl_out.aux_voltage_code   <=
                aux_ctrl_q[AUX_VOLTAGE_MSB:AUX_VOLTAGE_LSB];
            rail_ctrl_out.aux_ldo_one_on     <= (target_q == TARGET_AUX_LDO) && rail_on;
            rail_ctrl_out.load_switch_b2_on  <=
                (target_q == TARGET_SWITCH_B2) && rail_on;
        end
    end

endmodule : rail_control_status_regs

// ==== verif/rail_ctrl_asserts.sv ====
`timescale 1ns/10ps
module rail_ctrl_asserts
    import rail_regs_pkg::*;
#(
    parameter int MS_CYCLES = CYCLES_PER_MS
) (
    input wire logic       clk_in,
    input wire logic       rst_b_in,
    input wire otp_cfg_s   otp_cfg_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       reg_ready_out,
    input wire logic       reg_hit_out,
    input wire logic       emergency_shutdown_in,
    input wire logic       aux_two_good_in,
    input wire logic       switch_a1_good_in,
    input wire logic       converter6_good_in,
    input wire logic       converter5_good_in,
    input wire logic       converter4_good_in,
    input wire logic       converter3_good_in,
    input wire logic       converter2_good_in,
    input wire logic       converter1_good_in,
    input wire rail_ctrl_s rail_ctrl_out
);
    // One clock domain; reset masks every check
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // Helper terms shared by the checks
    wire logic [7:0] good_vec = {aux_two_good_in, switch_a1_good_in, converter6_good_in,
        converter5_good_in, converter4_good_in, converter3_good_in, converter2_good_in,
        converter1_good_in};
    wire logic wr_take = reg_wr_in && reg_ready_out;
    wire logic wr_aux  = wr_take && reg_addr_in == AUX_RAIL_CTRL_ADDR;
    wire logic rd_stat = reg_rd_in && reg_ready_out && reg_addr_in == RAIL_GOOD_STATUS_A_ADDR;
    wire logic rail_on = rail_ctrl_out.aux_ldo_one_on || rail_ctrl_out.load_switch_b2_on;

    status_map_a: assert property (
        $stable(good_vec)[*4] ##0 rd_stat |=> reg_rdata_out == $past(good_vec))
        else $error("status read differs from good pins");
    hit_decode_a: assert property (reg_hit_out == (reg_addr_in == TERM_DISCHARGE_CTRL_ADDR
        || reg_addr_in == AUX_RAIL_CTRL_ADDR || reg_addr_in == RAIL_GOOD_STATUS_A_ADDR))
        else $error("address decode wrong");
    aux_fields_a: assert property (wr_aux |-> ##2
        rail_ctrl_out.aux_discharge_sel == $past(reg_wdata_in[7:6], 2)
        && rail_ctrl_out.aux_voltage_code == $past(reg_wdata_in[4:1], 2))
        else $error("aux fields not applied");
    term_field_a: assert property (
        wr_take && reg_addr_in == TERM_DISCHARGE_CTRL_ADDR |-> ##2
        rail_ctrl_out.term_discharge_sel == $past(reg_wdata_in[4], 2))
        else $error("termination discharge not applied");
    enable_follow_a: assert property (
        wr_aux && reg_wdata_in[5] && !otp_cfg_in.aux_bit_unused |-> ##2
        rail_on == $past(reg_wdata_in[0], 2))
        else $error("rail does not follow enable");
    unused_off_a: assert property (otp_cfg_in.aux_bit_unused |-> !rail_on)
        else $error("unused option drives a rail");
    b2_target_a: assert property (rail_ctrl_out.load_switch_b2_on |->
        otp_cfg_in.aux_in_sequence && !otp_cfg_in.switches_b_merged)
        else $error("switch b2 driven on wrong option");
    otp_load_a: assert property ($rose(rst_b_in) |-> ##[2:3]
        rail_ctrl_out.aux_voltage_code == otp_cfg_in.aux_ctrl[4:1]
        && rail_ctrl_out.term_discharge_sel == otp_cfg_in.term_ctrl[4])
        else $error("factory preload missing");
    ready_load_a: assert property ($rose(rst_b_in) |-> !reg_ready_out ##1 reg_ready_out)
        else $error("ready not raised after preload");

    // Main scenarios reached
    cover property (wr_aux);
    cover property (rd_stat);
    cover property ($rose(emergency_shutdown_in) ##[4:6] !rail_on);
    cover property (rail_ctrl_out.load_switch_b2_on);
endmodule : rail_ctrl_asserts

bind rail_control_status_regs rail_ctrl_asserts #(.MS_CYCLES(MS_CYCLES)) i_rail_ctrl_asserts (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .otp_cfg_in(otp_cfg_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_ready_out(reg_ready_out), .reg_hit_out(reg_hit_out),
    .emergency_shutdown_in(emergency_shutdown_in), .aux_two_good_in(aux_two_good_in),
    .switch_a1_good_in(switch_a1_good_in), .converter6_good_in(converter6_good_in),
    .converter5_good_in(converter5_good_in), .converter4_good_in(converter4_good_in),
    .converter3_good_in(converter3_good_in), .converter2_good_in(converter2_good_in),
    .converter1_good_in(converter1_good_in), .rail_ctrl_out(rail_ctrl_out));

// ==== verif/rail_control_status_regs_bench.sv ====
`timescale 1ns/10ps
module rail_control_status_regs_bench
    import rail_regs_pkg::*;
;
    // Short ms keeps the 100 ms case cheap
    localparam int MS = 4;
    typedef struct packed {logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} row_s;
    logic       clk_in, rst_b_in, reg_wr_in, reg_rd_in, emergency_shutdown_in;
    logic       reg_ready_out, reg_hit_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, good_q, got;
    otp_cfg_s   otp_cfg_in, cfg;
    rail_ctrl_s rail_ctrl_out;
    int         mismatches, n_compared, n_off;
    int         ms_tab [4] = '{SHUTDOWN_MS_0, SHUTDOWN_MS_1, SHUTDOWN_MS_2, SHUTDOWN_MS_3};
    logic [4:0] tgt [3] = '{5'h11, 5'h1A, 5'h14};
    row_s       rows [8] = '{'{8'hAD, 8'h5F, 8'h5F}, '{8'hAD, 8'h4F, 8'h4F},
        '{8'hAE, 8'h21, 8'h21}, '{8'hAE, 8'h7E, 8'h7E}, '{8'hAE, 8'hAB, 8'hAB},
        '{8'hAE, 8'hF4, 8'hF4}, '{8'hB0, 8'hFF, 8'hA5}, '{8'hC5, 8'h12, 8'h00}};

    // Device under test; good pins come from one vector
    rail_control_status_regs #(.MS_CYCLES(MS)) i_rail_control_status_regs (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .otp_cfg_in(otp_cfg_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .reg_ready_out(reg_ready_out), .reg_hit_out(reg_hit_out),
        .emergency_shutdown_in(emergency_shutdown_in), .aux_two_good_in(good_q[7]),
        .switch_a1_good_in(good_q[6]), .converter6_good_in(good_q[5]),
        .converter5_good_in(good_q[4]), .converter4_good_in(good_q[3]),
        .converter3_good_in(good_q[2]), .converter2_good_in(good_q[1]),
        .converter1_good_in(good_q[0]), .rail_ctrl_out(rail_ctrl_out));

    // 25 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Strobes held across exactly one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        got = reg_rdata_out;
    endtask : rd

    // Three edges after release covers the preload
    // Options change only while reset is low, as on a real power-up
    task automatic do_reset(input otp_cfg_s c);
        @(posedge clk_in);
        rst_b_in   <= 1'b0;
        otp_cfg_in <= c;
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
    endtask : do_reset

    // Counts off cycles in a window longer than the 100 ms case
    task automatic off_time(input logic [7:0] ctrl);
        wr(AUX_RAIL_CTRL_ADDR, ctrl);
        repeat (3) @(posedge clk_in);
        emergency_shutdown_in <= 1'b1;
        n_off = 0;
        repeat (500) begin
            @(negedge clk_in);
            n_off += (rail_ctrl_out.aux_ldo_one_on !== 1'b1);
        end
        @(posedge clk_in);
        emergency_shutdown_in <= 1'b0;
    endtask : off_time

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // Whole run is near 3000 cycles
    initial begin
        #(40 * 20_000);
        mismatches++;
        wrap_up();
    end

    initial begin
        {rst_b_in, reg_wr_in, reg_rd_in, emergency_shutdown_in} = '0;
        {reg_addr_in, reg_wdata_in, good_q} = '0;
        otp_cfg_in = '{term_ctrl: 8'h5F, aux_ctrl: 8'h4A, default: '0};
        do_reset(otp_cfg_in);
        rd(TERM_DISCHARGE_CTRL_ADDR);
        check(got, 8'h5F);
        check(reg_ready_out, 1'b1);
        rd(AUX_RAIL_CTRL_ADDR);
        check(got, 8'h4A);
        rd(RAIL_GOOD_STATUS_A_ADDR);
        check(got, 8'h00);
        $display("reset test done");
        @(posedge clk_in);
        good_q <= 8'hA5;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].data);
            rd(rows[i].addr);
            check(got, rows[i].exp);
            check(reg_hit_out, rows[i].addr inside {8'hAD, 8'hAE, 8'hB0});
            if (rows[i].addr == TERM_DISCHARGE_CTRL_ADDR)
                check(rail_ctrl_out.term_discharge_sel, rows[i].data[4]);
            if (rows[i].addr == AUX_RAIL_CTRL_ADDR) begin
                check(rail_ctrl_out.aux_discharge_sel, rows[i].data[7:6]);
                check(rail_ctrl_out.aux_voltage_code, rows[i].data[4:1]);
                check(rail_ctrl_out.aux_ldo_one_on, rows[i].data[0]);
            end
        end
        $display("register table test done");
        // Walking one maps each pin to its bit
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in);
            good_q <= 8'h01 << i;
            repeat (4) @(posedge clk_in);
            rd(RAIL_GOOD_STATUS_A_ADDR);
            check(got, 8'h01 << i);
        end
        $display("status map test done");
        for (int k = 0; k < 4; k++) begin
            cfg = otp_cfg_in;
            cfg.shutdown_time = 2'(k);
            do_reset(cfg);
            off_time(8'h01);
            check(n_off[15:0], 16'(MS * ms_tab[k]));
        end
        off_time(8'h21);
        check(n_off[15:0], 16'h0000);
        $display("shutdown test done");
        // Factory options steer the fields or leave them idle
        for (int k = 0; k < 3; k++) begin
            cfg = otp_cfg_in;
            {cfg.aux_in_sequence, cfg.switches_b_merged, cfg.aux_bit_unused} = tgt[k][4:2];
            do_reset(cfg);
            wr(AUX_RAIL_CTRL_ADDR, 8'h21);
            repeat (3) @(negedge clk_in);
            check({rail_ctrl_out.aux_ldo_one_on, rail_ctrl_out.load_switch_b2_on},
                tgt[k][1:0]);
        end
        $display("target test done");
        wrap_up();
    end
endmodule : rail_control_status_regs_bench
